//--- include/adcs_pkg.sv
// Constants and types shared by the converter serial port design.
package adcs_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int PAD_W = WORD_W - CODE_W;
  localparam int FRAME_BITS = 32;
  localparam int HALF_BITS = 16;
  localparam int CNT_W = 5;
  // Configuration field positions.
  localparam int SS_BIT = 15;
  localparam int MUX_HI = 14;
  localparam int MUX_LO = 12;
  localparam int PGA_HI = 11;
  localparam int PGA_LO = 9;
  localparam int MODE_BIT = 8;
  localparam int DR_HI = 7;
  localparam int DR_LO = 5;
  localparam int TS_BIT = 4;
  localparam int PU_BIT = 3;
  localparam int WV_HI = 2;
  localparam int WV_LO = 1;
  localparam int RSV_BIT = 0;
  // Reset values and codes.
  localparam logic [15:0] CFG_RESET = 16'h058b;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [1:0] WRITE_VALID = 2'h1;
  localparam logic [15:0] SAT_POS = 16'h7ff0;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  // Timing.
  localparam int CLK_HZ = 40_000_000;
  localparam real READY_LEAD_US = 8.0;
  localparam int READY_LEAD_CYC = int'(READY_LEAD_US * CLK_HZ / 1.0e6);
  localparam real IDLE_TMO_MS = 28.0;
  localparam int IDLE_TMO_CYC = int'(IDLE_TMO_MS * CLK_HZ / 1.0e3);
  typedef enum logic [2:0] {
    ADCS_OFF = 3'b001,
    ADCS_SINGLE = 3'b010,
    ADCS_CONT = 3'b100
  } adcs_state_type;
endpackage

//--- src/adcs_port.sv
// Serial data and configuration port of a small delta-sigma converter.
// Functional notes
// R1: With chip select high, line is weakly pulled up, or floats if pullup field is 0.
// R2: Result is a 12-bit twos-complement code left-justified in 16 bits.
// R3: Output code saturates at 7FF0h and 8000h, never wrapping.
// R4: Mode 0 launches conversions back to back whatever chip select does.
// R5: Mode 1 starts a conversion only when the host writes the start bit.
// R6: Latest result is buffered until replaced, so reads are always coherent.
// R7: Result bit 15 leaves on the first rising serial clock edge, then descending.
// R8: Configuration bits are sampled from the input on falling serial clock edges.
// R9: A transfer is 32 clocks with echo, or 16 clocks when chip select is driven.
// R10: A 32-clock transfer sends two result bytes then two echo bytes, MSB first.
// R11: Host repeats the word or holds input steady in the second half.
// R12: Last two bytes echo the configuration written in the first two bytes.
// R13: In short transfers the host raises chip select after the sixteenth clock.
// R14: Next chip select assertion shifts out the buffered result from the first edge.
// R15: Without a new result, the previous result is resent unchanged.
// R16: Result register holds 0000h after reset until the first conversion ends.
// R17: Result register is read-only with bits 3:0 always zero.
// R18: Configuration resets to 058Bh with the documented field layout.
// R19: Exactly two registers: read-only result and writable configuration.
// R20: Same framing in both modes with no command bytes.
// R21: Chip select high resets the serial interface and releases the line.
// R22: Ready goes low on a new result, high 8 us before the next if unread.
// R23: Serial clock low for 28 ms resets the serial interface.
// R24: Start powers up, clears itself, converts once, powers down; ignored if busy.
// R25: Front-end settings pass unchanged and apply from the next conversion start.
module adcs_port #(
  parameter int AFE_W = 16,
  parameter int PER_W = 24,
  parameter int TMO_CYC = adcs_pkg::IDLE_TMO_CYC
) (
  input wire logic clk, // Device clock.
  input wire logic arst_n, // Power-up reset.
  input wire logic sclk, // Serial clock from the host.
  input wire logic cs_n, // Chip select, active low.
  input wire logic din, // Serial data in.
  output logic dout_o, // Data out and ready level.
  output logic dout_oe, // High while the line is driven.
  output logic dout_pullup, // Weak pullup enable while released.
  input wire logic afe_valid, // Front end finished a conversion.
  input wire logic signed [AFE_W-1:0] afe_code, // Raw signed code in result LSBs.
  output logic afe_start, // Pulse that starts a conversion.
  output logic afe_power, // Front end powered.
  output logic [2:0] afe_input_select, // Input selection.
  output logic [2:0] afe_gain_select, // Gain selection.
  output logic [2:0] afe_rate_select, // Rate selection.
  output logic afe_temp_sensor_select // Temperature sensor selection.
);
  import adcs_pkg::*;

  localparam logic signed [AFE_W-1:0] CODE_MAX = AFE_W'(2047);
  localparam logic signed [AFE_W-1:0] CODE_MIN = -AFE_W'(2048);
  localparam logic [PER_W-1:0] LEAD = PER_W'(READY_LEAD_CYC);
  localparam logic [31:0] TMO_LAST = 32'(TMO_CYC - 1);

  function automatic logic cfg_ok(input logic [15:0] w);
    cfg_ok = (w[WV_HI:WV_LO] == WRITE_VALID);
  endfunction

  function automatic logic [15:0] cfg_clean(input logic [15:0] w);
    cfg_clean = {1'b0, w[MUX_HI:WV_LO], 1'b1};
  endfunction

  logic [15:0] cfg_q;
  logic [15:0] result_q;
  logic [15:0] shadow_q;
  logic new_q;
  logic started_q;
  logic tmo_q;
  logic [31:0] tmo_cnt_q;
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] last_per_q;
  adcs_state_type state_q;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic wtog_seen_q;
  logic etog_seen_q;
  logic [CNT_W-1:0] rcnt_q;
  logic [CNT_W-1:0] fcnt_q;
  logic [15:0] tx_q;
  logic tx_bit_q;
  logic active_q;
  logic [15:0] rx_q;
  logic [15:0] cfg_rx_q;
  logic wtog_q;
  logic etog_q;
  logic link_rst_n;
  logic cs_s;
  logic sclk_s;
  logic wr_evt;
  logic end_evt;
  logic wr_go;
  logic ss_go;
  logic [15:0] sat_code;
  logic [15:0] tx_word;
  logic [15:0] cfg_now;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for the pins and the link toggles.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 4'h1;
      s2_q <= 4'h1;
    end else begin
      s1_q <= {etog_q, wtog_q, sclk, cs_n};
      s2_q <= s1_q;
    end
  end

  assign cs_s = s2_q[0];
  assign sclk_s = s2_q[1];
  assign wr_evt = s2_q[2] ^ wtog_seen_q;
  assign end_evt = s2_q[3] ^ etog_seen_q;
  assign wr_go = wr_evt && cfg_ok(cfg_rx_q);
  assign ss_go = wr_go && cfg_rx_q[SS_BIT];
  // A write that launches a conversion must reach the front end with that conversion.
  assign cfg_now = wr_go ? cfg_clean(cfg_rx_q) : cfg_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wtog_seen_q <= 1'b0;
      etog_seen_q <= 1'b0;
    end else begin
      wtog_seen_q <= s2_q[2];
      etog_seen_q <= s2_q[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration register; the start bit is never stored.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= CFG_RESET; // R18
    end else if (wr_go) begin
      cfg_q <= cfg_clean(cfg_rx_q); // R18 R24
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencing.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ADCS_OFF;
    end else begin
      unique case (state_q)
        ADCS_OFF: begin
          if (!cfg_q[MODE_BIT]) begin
            state_q <= ADCS_CONT; // R4
          end else if (ss_go && cfg_rx_q[MODE_BIT]) begin
            state_q <= ADCS_SINGLE; // R5
          end
        end
        ADCS_SINGLE: begin
          if (afe_valid) begin
            state_q <= cfg_q[MODE_BIT] ? ADCS_OFF : ADCS_CONT; // R24
          end
        end
        ADCS_CONT: begin
          if (afe_valid && cfg_q[MODE_BIT]) begin
            state_q <= ADCS_OFF;
          end
        end
      endcase
    end
  end

  // One start pulse per launch; a start asked for while busy is dropped.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      afe_start <= 1'b0;
    end else begin
      unique case (state_q)
        ADCS_OFF: begin
          afe_start <= !cfg_q[MODE_BIT] || (ss_go && cfg_rx_q[MODE_BIT]); // R5 R24
        end
        ADCS_SINGLE: begin
          afe_start <= afe_valid && !cfg_q[MODE_BIT];
        end
        ADCS_CONT: begin
          afe_start <= afe_valid && !cfg_q[MODE_BIT]; // R4
        end
      endcase
    end
  end

  // Power stays up through a continuous run and drops with a single result.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      afe_power <= 1'b0;
    end else begin
      unique case (state_q)
        ADCS_OFF: begin
          afe_power <= !cfg_q[MODE_BIT] || (ss_go && cfg_rx_q[MODE_BIT]); // R24
        end
        ADCS_SINGLE: begin
          afe_power <= !(afe_valid && cfg_q[MODE_BIT]); // R24
        end
        ADCS_CONT: begin
          afe_power <= !(afe_valid && cfg_q[MODE_BIT]);
        end
      endcase
    end
  end

  // Settings are captured as each conversion is launched, so a write that
  // also starts a single conversion reaches the front end with it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      afe_input_select <= CFG_RESET[MUX_HI:MUX_LO];
      afe_gain_select <= CFG_RESET[PGA_HI:PGA_LO];
      afe_rate_select <= CFG_RESET[DR_HI:DR_LO];
      afe_temp_sensor_select <= CFG_RESET[TS_BIT];
    end else if (state_q == ADCS_OFF || afe_valid) begin
      afe_input_select <= cfg_now[MUX_HI:MUX_LO]; // R25
      afe_gain_select <= cfg_now[PGA_HI:PGA_LO]; // R25
      afe_rate_select <= cfg_now[DR_HI:DR_LO]; // R25
      afe_temp_sensor_select <= cfg_now[TS_BIT]; // R25
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result formatting, buffering and ready indication.
  always_comb begin
    if (afe_code >= CODE_MAX) begin
      sat_code = SAT_POS; // R3
    end else if (afe_code <= CODE_MIN) begin
      sat_code = SAT_NEG; // R3
    end else begin
      sat_code = {afe_code[CODE_W-1:0], {PAD_W{1'b0}}}; // R2 R17
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= RESULT_RESET; // R16
    end else if (afe_valid && state_q != ADCS_OFF) begin
      result_q <= sat_code; // R6
    end
  end

  // A transfer in progress keeps its snapshot; otherwise it follows the result.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      started_q <= 1'b0;
    end else if (cs_s || tmo_q || end_evt) begin
      started_q <= 1'b0; // R21
    end else if (sclk_s) begin
      started_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shadow_q <= RESULT_RESET;
    end else if (!started_q && !sclk_s) begin
      shadow_q <= result_q; // R6 R14 R15
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      per_cnt_q <= '0;
    end else if (afe_valid) begin
      per_cnt_q <= '0;
    end else if (per_cnt_q != '1) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // The last measured interval predicts when the next result lands.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_per_q <= '0;
    end else if (afe_valid) begin
      last_per_q <= per_cnt_q;
    end
  end

  // A fresh result wins over a read that starts in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      new_q <= 1'b0;
    end else if (afe_valid && state_q != ADCS_OFF) begin
      new_q <= 1'b1; // R22
    end else if (started_q) begin
      new_q <= 1'b0; // R15
    end else if (state_q == ADCS_CONT && last_per_q > LEAD
                 && per_cnt_q == last_per_q - LEAD) begin
      new_q <= 1'b0; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Idle serial clock timeout; a one-cycle pulse resets the link.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tmo_cnt_q <= '0;
      tmo_q <= 1'b0;
    end else if (sclk_s) begin
      tmo_cnt_q <= '0;
      tmo_q <= 1'b0;
    end else begin
      tmo_q <= (tmo_cnt_q == TMO_LAST); // R23
      if (tmo_cnt_q <= TMO_LAST) begin
        tmo_cnt_q <= tmo_cnt_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link logic on the serial clock, held in reset while deselected.
  assign link_rst_n = arst_n && !cs_n && !tmo_q; // R21 R23

  always_comb begin
    if (rcnt_q == '0) begin
      tx_word = shadow_q; // R14
    end else if (rcnt_q == CNT_W'(HALF_BITS)) begin
      tx_word = cfg_ok(cfg_rx_q) ? cfg_clean(cfg_rx_q) : cfg_q; // R12
    end else begin
      tx_word = tx_q;
    end
  end

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rcnt_q <= '0;
      tx_q <= '0;
      tx_bit_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      rcnt_q <= rcnt_q + 1'b1; // R9
      tx_bit_q <= tx_word[15]; // R7 R10
      tx_q <= {tx_word[14:0], 1'b0}; // R10
      active_q <= 1'b1;
    end
  end

  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fcnt_q <= '0;
      rx_q <= '0;
    end else begin
      fcnt_q <= fcnt_q + 1'b1;
      rx_q <= {rx_q[14:0], din}; // R8
    end
  end

  // Received word and event toggles survive deselection for the crossing.
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rx_q <= '0;
      wtog_q <= 1'b0;
    end else if (link_rst_n && fcnt_q == CNT_W'(HALF_BITS - 1)) begin
      cfg_rx_q <= {rx_q[14:0], din}; // R8 R20
      wtog_q <= !wtog_q;
    end
  end

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      etog_q <= 1'b0;
    end else if (link_rst_n && rcnt_q == CNT_W'(FRAME_BITS - 1)) begin
      etog_q <= !etog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive: shifted data once clocking starts, ready level before that.
  assign dout_oe = !cs_n; // R1 R21
  assign dout_o = active_q ? tx_bit_q : !new_q; // R22
  assign dout_pullup = cs_n && cfg_q[PU_BIT]; // R1

endmodule // adcs_port

//--- verif/adcs_port_sva.sv
// Concurrent checks on the converter serial port pins.
module adcs_port_sva (
  input wire logic clk, // Device clock.
  input wire logic arst_n, // Power-up reset.
  input wire logic cs_n, // Chip select.
  input wire logic dout_oe, // Line driven.
  input wire logic dout_pullup, // Weak pullup on.
  input wire logic afe_valid, // Conversion done.
  input wire logic afe_start, // Conversion start pulse.
  input wire logic afe_power, // Front end powered.
  input wire logic [2:0] afe_input_select, // Input selection.
  input wire logic [2:0] afe_gain_select, // Gain selection.
  input wire logic [2:0] afe_rate_select, // Rate selection.
  input wire logic afe_temp_sensor_select // Temperature sensor selection.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence conv_done;
    afe_valid && afe_power;
  endsequence
  chk_oe_follows_cs: assert property (dout_oe == !cs_n)
    else $error("line enable does not follow chip select");
  chk_pullup_sel_off: assert property (!cs_n |-> !dout_pullup)
    else $error("pullup on while selected");
  chk_start_one_pulse: assert property (afe_start |=> !afe_start)
    else $error("start pulse longer than one cycle");
  chk_start_powers_up: assert property (afe_start |-> afe_power)
    else $error("start without power");
  chk_restart_or_off: assert property (conv_done |=> afe_power == afe_start)
    else $error("wrong action after a conversion");
  chk_busy_no_start: assert property (afe_power && !afe_valid |=> !afe_start)
    else $error("start while busy");
  chk_settings_hold: assert property (afe_power && !afe_start && !afe_valid |=>
    $stable({afe_input_select, afe_gain_select, afe_rate_select, afe_temp_sensor_select}))
    else $error("settings changed during a conversion");
  chk_reset_off: assert property ($rose(arst_n) |-> !afe_power [*3])
    else $error("powered up after reset");
endmodule // adcs_port_sva
bind adcs_port adcs_port_sva i_sva (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .dout_oe(dout_oe),
  .dout_pullup(dout_pullup), .afe_valid(afe_valid), .afe_start(afe_start),
  .afe_power(afe_power), .afe_input_select(afe_input_select),
  .afe_gain_select(afe_gain_select), .afe_rate_select(afe_rate_select),
  .afe_temp_sensor_select(afe_temp_sensor_select));

//--- verif/adcs_host.sv
// Host controller model that runs serial frames.
module adcs_host (
  input wire logic clk, // Device clock for pacing.
  input wire logic dout_o, // Line value from the device.
  input wire logic dout_oe, // Device drives the line.
  input wire logic dout_pullup, // Weak pullup on.
  output logic sclk, // Serial clock, idle low.
  output logic cs_n, // Chip select.
  output logic din // Serial data to the device.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic line_v;
  // A floating line shows a changing value, never a stale one.
  assign line_v = dout_oe ? dout_o : (dout_pullup ? 1'b1 : ~din);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic xfer(input int n, input logic [15:0] w, input logic rep,
                      output logic rdy, output logic [31:0] rx);
    int i;
    rx = '0;
    @(posedge clk) cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    rdy = line_v;
    for (i = 0; i < n; i++) begin
      #1 sclk = 1'b1;
      #2 din = (i < 16 || rep) ? w[15 - i % 16] : 1'b0;
      rx = {rx[30:0], line_v};
      #1 sclk = 1'b0;
      #2;
    end
    @(posedge clk) cs_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // Clocks a few bits and stops with chip select still low, like a cut-off host.
  task automatic part(input int n);
    @(posedge clk) cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    repeat (n) begin
      #1 sclk = 1'b1;
      #3 sclk = 1'b0;
      #2;
    end
  endtask
endmodule // adcs_host

//--- verif/test_adcs_port.sv
// Self-checking bench for the converter serial port.
module test_adcs_port;
  timeunit 1ns;
  timeprecision 1ps;
  import adcs_pkg::*;
  logic clk, arst_n, sclk, cs_n, din, dout_o, dout_oe, dout_pullup, rdy;
  logic afe_valid, afe_start, afe_power, afe_temp_sensor_select;
  logic signed [15:0] afe_code;
  logic [2:0] afe_input_select, afe_gain_select, afe_rate_select;
  logic [31:0] rx;
  int mismatches, n_compared, wait_cnt, n_start, base;
  logic signed [15:0] codes [3] = '{-16'sd5000, -16'sd1, 16'sd5};
  logic [15:0] exps [3] = '{16'h8000, 16'hfff0, 16'h0050};
  ////////////////////////////////////////////////////////////////////
  adcs_port #(.TMO_CYC(200)) i_dut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .dout_pullup(dout_pullup),
    .afe_valid(afe_valid), .afe_code(afe_code), .afe_start(afe_start), .afe_power(afe_power),
    .afe_input_select(afe_input_select), .afe_gain_select(afe_gain_select),
    .afe_rate_select(afe_rate_select), .afe_temp_sensor_select(afe_temp_sensor_select));
  adcs_host i_host (.clk(clk), .dout_o(dout_o), .dout_oe(dout_oe), .dout_pullup(dout_pullup),
    .sclk(sclk), .cs_n(cs_n), .din(din));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The front end answers every start 20 cycles later.
  always @(posedge clk) begin
    if (!arst_n) begin
      afe_valid <= 1'b0;
      wait_cnt <= 0;
      n_start <= 0;
    end else begin
      afe_valid <= (wait_cnt == 1);
      if (afe_start === 1'b1) begin
        wait_cnt <= 20;
        n_start <= n_start + 1;
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conv(input logic signed [15:0] code);
    int k;
    afe_code <= code;
    for (k = 0; k < 200 && afe_valid !== 1'b1; k++) @(posedge clk);
    cmp("conversion done", 16'h0001, {15'h0000, afe_valid});
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // The whole sequence needs under a thousand cycles; 200 us is ample.
  initial begin
    #200us;
    mismatches++;
    close_out();
  end
  initial begin
    arst_n = 1'b0;
    afe_code = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("pullup idle", 16'h0001, {15'h0000, dout_pullup});
    cmp("gain reset", 16'h0002, {13'h0000, afe_gain_select});
    cmp("rate reset", 16'h0004, {13'h0000, afe_rate_select});
    i_host.xfer(32, 16'h0000, 1'b1, rdy, rx);
    cmp("result at reset", RESULT_RESET, rx[31:16]);
    cmp("config at reset", CFG_RESET, rx[15:0]);
    i_host.xfer(32, 16'hbbd2, 1'b1, rdy, rx);
    cmp("echo", 16'h3bd3, rx[15:0]);
    cmp("busy power", 16'h0001, {15'h0000, afe_power});
    cmp("busy gain", 16'h0005, {13'h0000, afe_gain_select});
    cmp("busy input", 16'h0003, {13'h0000, afe_input_select});
    conv(16'sd3000);
    cmp("input select", 16'h0003, {13'h0000, afe_input_select});
    cmp("gain select", 16'h0005, {13'h0000, afe_gain_select});
    cmp("rate select", 16'h0006, {13'h0000, afe_rate_select});
    cmp("temp select", 16'h0001, {15'h0000, afe_temp_sensor_select});
    cmp("powered down", 16'h0000, {15'h0000, afe_power});
    i_host.xfer(16, 16'h0000, 1'b0, rdy, rx);
    cmp("ready low", 16'h0000, {15'h0000, rdy});
    cmp("positive clip", SAT_POS, rx[15:0]);
    i_host.xfer(16, 16'h0000, 1'b0, rdy, rx);
    cmp("ready high", 16'h0001, {15'h0000, rdy});
    cmp("resend", SAT_POS, rx[15:0]);
    for (int i = 0; i < 3; i++) begin
      i_host.xfer(32, 16'h8183, 1'b0, rdy, rx);
      cmp("echo held low", 16'h0183, rx[15:0]);
      cmp("pullup off", 16'h0000, {15'h0000, dout_pullup});
      conv(codes[i]);
      i_host.xfer(16, 16'h0000, 1'b0, rdy, rx);
      cmp("result", exps[i], rx[15:0]);
    end
    i_host.part(5);
    repeat (230) @(posedge clk);
    i_host.xfer(16, 16'h0000, 1'b0, rdy, rx);
    cmp("ready after idle", 16'h0001, {15'h0000, rdy});
    cmp("result after idle", exps[2], rx[15:0]);
    base = n_start;
    i_host.xfer(32, 16'h008b, 1'b1, rdy, rx);
    repeat (100) @(posedge clk);
    cmp("continuous", 16'h0001, {15'h0000, n_start - base >= 3});
    i_host.xfer(16, 16'h0000, 1'b0, rdy, rx);
    cmp("continuous result", exps[2], rx[15:0]);
    i_host.xfer(32, 16'h018b, 1'b1, rdy, rx);
    repeat (60) @(posedge clk);
    base = n_start;
    repeat (60) @(posedge clk);
    cmp("single idle", 16'h0000, {15'h0000, afe_power});
    cmp("no starts", 16'h0000, 16'(n_start - base));
    close_out();
  end
endmodule // test_adcs_port
